// *** src/wcc_host.sv ***
`timescale 1ns/1ps
`include "wcc_defs.svh"
// Behaviour
// - Checksum is 8-bit, combinational XOR tree over a 72-bit code word.
// - Generator polynomial is x^8 + x^2 + x + 1.
// - Bit 71 is the first bit shifted into the serial view.
// - Checksum register starts from all zeros.
// - Four-bit width: 32 data bits, bits 71 to 32 forced to ones.
// - Eight-bit width: 64 data bits, top 8 carry mask/inversion or ones.
// - Eight/sixteen-bit widths: controller drives ones in beat 9.
// - Without masking, controller rewrites good data over errored writes.
// - Controller never enables write inversion together with masking.
// - No command spacing of 4 (one-clock) or 6 (two-clock preamble).
// - With checksum on, no page writes and no per-device addressing.
// - Checksum bursts are sequential, low three column bits zero.
// - Each checksum bit equals the XOR of its published data set.
module wcc_host (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wr_req,
  input wire logic [9:0] wr_col,
  input wire logic [63:0] wr_data,
  input wire logic [7:0] wr_byte_mask_n,
  input wire logic cfg_x4,
  input wire logic cfg_crc_en,
  input wire logic cfg_dm_en,
  input wire logic cfg_dbi_en,
  input wire logic cfg_pre2,
  input wire logic cfg_mpr,
  input wire logic cfg_per_dev,
  output logic wr_ready,
  output logic wr_refused,
  output logic wr_done,
  output logic wr_rewrite,
  output logic link_ck,
  output logic wr_cmd,
  output logic [9:0] col_addr,
  output logic [7:0] dq_o,
  output logic dq_oe,
  output logic write_byte_mask_n,
  output logic write_byte_mask_oe,
  input wire logic alert_n
);
  import wcc_pkg::*;

  // ****************
  // Checksum tree
  // ****************
  function automatic logic [7:0] wcc_crc(input wcc_word_t d);
    logic [7:0] c;
    logic fb;
    c = `WCC_CRC_INIT;
    fb = 1'b0;
    for (int i = 71; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? `WCC_POLY : 8'h00);
    end
    return c;
  endfunction

  // Inverts a beat when more than four lanes would be low
  function automatic logic wcc_invert(input logic [7:0] beat);
    int zeros;
    zeros = 0;
    for (int i = 0; i < 8; i++) begin
      zeros = zeros + (beat[i] ? 0 : 1);
    end
    return zeros > 4;
  endfunction

  // ****************
  // Link clock divider
  // ****************
  localparam logic [2:0] HALF = 3'(`WCC_LINK_HALF - 1);
  logic [2:0] div;
  logic tick;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div <= 3'h0;
      link_ck <= 1'b0;
    end else if (div == HALF) begin
      div <= 3'h0;
      link_ck <= ~link_ck;
    end else begin
      div <= div + 3'h1;
    end
  end

  // Beats launch on the falling link edge
  assign tick = (div == HALF) && link_ck;

  // ****************
  // Alert synchroniser
  // ****************
  logic alert_m;
  logic alert_s;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alert_m <= 1'b1;
      alert_s <= 1'b1;
    end else begin
      alert_m <= alert_n;
      alert_s <= alert_m;
    end
  end

  // ****************
  // Code word build
  // ****************
  wcc_word_t next_word;
  logic refuse;
  logic accept;

  always_comb begin
    logic [7:0] beat;
    logic inv;
    beat = 8'h00;
    inv = 1'b0;
    next_word = '1;
    for (int b = 0; b < 8; b++) begin
      for (int l = 0; l < 8; l++) begin
        beat[l] = wr_data[l*8+b];
      end
      inv = cfg_dbi_en && !cfg_x4 && wcc_invert(beat);
      for (int l = 0; l < 8; l++) begin
        if (!cfg_x4 || l < 4) begin
          next_word[l*8+b] = beat[l] ^ inv;
        end
      end
      if (!cfg_x4 && cfg_dbi_en) begin
        next_word[64+b] = ~inv;
      end else if (!cfg_x4 && cfg_dm_en) begin
        next_word[64+b] = wr_byte_mask_n[b];
      end
    end
  end

  assign refuse = (cfg_dm_en && cfg_dbi_en)
    || (cfg_crc_en && (cfg_mpr || cfg_per_dev));
  assign accept = wr_req && wr_ready;

  // ****************
  // Frame sequencer
  // ****************
  wcc_state_t state;
  wcc_word_t word;
  logic [7:0] crc;
  logic [3:0] beat_cnt;
  logic [3:0] gap;
  logic [4:0] watch;
  logic err_seen;
  logic [3:0] last_beat;
  logic [3:0] bad_gap;

  assign last_beat = cfg_crc_en ? `WCC_BEATS_CRC - 4'h1
                                : `WCC_BEATS_PLAIN - 4'h1;
  assign bad_gap = cfg_pre2 ? `WCC_GAP_PRE2 : `WCC_GAP_PRE1;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      word <= '1;
      crc <= 8'h00;
      col_addr <= 10'h000;
    end else if (accept && !refuse) begin
      word <= next_word;
      crc <= wcc_crc(next_word);
      col_addr <= cfg_crc_en ? {wr_col[9:3], 3'h0} : wr_col;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gap <= 4'hf;
    end else if (tick && state == WCC_CMD && gap != bad_gap) begin
      gap <= 4'h1;
    end else if (tick && gap != 4'hf) begin
      gap <= gap + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= WCC_IDLE;
      beat_cnt <= 4'h0;
      watch <= 5'h00;
      err_seen <= 1'b0;
      wr_ready <= 1'b0;
      wr_refused <= 1'b0;
      wr_done <= 1'b0;
      wr_rewrite <= 1'b0;
    end else begin
      wr_refused <= accept && refuse;
      wr_done <= 1'b0;
      wr_rewrite <= 1'b0;
      wr_ready <= (state == WCC_IDLE) && !accept;
      case (state)
        WCC_IDLE: begin
          if (accept && !refuse) begin
            state <= WCC_CMD;
          end
        end
        WCC_CMD: begin
          if (tick && gap == bad_gap) begin
            state <= WCC_SPACE;
          end else if (tick) begin
            state <= WCC_SEND;
            beat_cnt <= 4'h0;
          end
        end
        WCC_SPACE: begin
          if (tick) begin
            state <= WCC_CMD;
          end
        end
        WCC_SEND: begin
          if (tick && beat_cnt == last_beat) begin
            state <= cfg_crc_en ? WCC_CHECK : WCC_IDLE;
            wr_done <= !cfg_crc_en;
            watch <= 5'h00;
            err_seen <= 1'b0;
          end else if (tick) begin
            beat_cnt <= beat_cnt + 4'h1;
          end
        end
        WCC_CHECK: begin
          if (!alert_s) begin
            err_seen <= 1'b1;
          end
          if (tick && watch == `WCC_ALERT_WIN - 5'h1) begin
            if (err_seen || !alert_s) begin
              state <= WCC_CMD;
              wr_rewrite <= 1'b1;
            end else begin
              state <= WCC_IDLE;
              wr_done <= 1'b1;
            end
          end else if (tick) begin
            watch <= watch + 5'h1;
          end
        end
        default: begin
          state <= WCC_IDLE;
        end
      endcase
    end
  end

  // ****************
  // Pin drive
  // ****************
  logic [3:0] next_beat;
  assign next_beat = (state == WCC_CMD) ? 4'h0 : beat_cnt + 4'h1;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_cmd <= 1'b0;
      dq_o <= 8'hff;
      dq_oe <= 1'b0;
      write_byte_mask_n <= 1'b1;
      write_byte_mask_oe <= 1'b0;
    end else if (tick) begin
      wr_cmd <= (state == WCC_CMD) && (gap != bad_gap);
      dq_oe <= 1'b0;
      write_byte_mask_oe <= 1'b0;
      dq_o <= 8'hff;
      write_byte_mask_n <= 1'b1;
      if (state == WCC_CMD && gap != bad_gap
          || state == WCC_SEND && beat_cnt != last_beat) begin
        dq_oe <= 1'b1;
        write_byte_mask_oe <= !cfg_x4 && (cfg_dm_en || cfg_dbi_en);
        if (next_beat < `WCC_BEAT_CRC_LO) begin
          for (int l = 0; l < 8; l++) begin
            dq_o[l] <= (cfg_x4 && l >= 4) ? 1'b1 : word[l*8+next_beat];
          end
          write_byte_mask_n <= word[64+next_beat];
        end else if (next_beat == `WCC_BEAT_CRC_LO) begin
          dq_o <= cfg_x4 ? {4'hf, crc[3:0]} : crc;
        end else begin
          dq_o <= cfg_x4 ? {4'hf, crc[7:4]} : 8'hff;
        end
      end
    end
  end

endmodule

// *** src/wcc_defs.svh ***
`ifndef WCC_DEFS_SVH
`define WCC_DEFS_SVH
// Link clock period in ns and local clock period in ns
`define WCC_LINK_PERIOD_NS 40
`define WCC_MCLK_NS 5
// Local clock cycles per half link clock
`define WCC_LINK_HALF (`WCC_LINK_PERIOD_NS / (2 * `WCC_MCLK_NS))
// Beats of a frame with and without checksum
`define WCC_BEATS_CRC 4'ha
`define WCC_BEATS_PLAIN 4'h8
`define WCC_BEAT_CRC_LO 4'h8
`define WCC_BEAT_CRC_HI 4'h9
// Forbidden command spacings in link clocks
`define WCC_GAP_PRE1 4'h4
`define WCC_GAP_PRE2 4'h6
// Link clocks to watch the alert after a frame
`define WCC_ALERT_WIN 5'h10
// Checksum polynomial low terms, x^2 + x + 1
`define WCC_POLY 8'h07
`define WCC_CRC_INIT 8'h00
`endif

// *** src/wcc_pkg.sv ***
package wcc_pkg;
  typedef enum logic [2:0] {
    WCC_IDLE = 3'b000,
    WCC_CMD = 3'b001,
    WCC_SEND = 3'b011,
    WCC_CHECK = 3'b010,
    WCC_SPACE = 3'b110
  } wcc_state_t;
  typedef logic [71:0] wcc_word_t;
endpackage

// *** verif/wcc_host_properties.sv ***
`timescale 1ns/1ps
// ********
// Checker
// ********
module wcc_host_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wr_req,
  input wire logic wr_ready,
  input wire logic wr_refused,
  input wire logic wr_done,
  input wire logic wr_rewrite,
  input wire logic link_ck,
  input wire logic wr_cmd,
  input wire logic [9:0] col_addr,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  input wire logic write_byte_mask_n,
  input wire logic write_byte_mask_oe,
  input wire logic alert_n,
  input wire logic cfg_x4,
  input wire logic cfg_crc_en,
  input wire logic cfg_dm_en,
  input wire logic cfg_dbi_en,
  input wire logic cfg_mpr,
  input wire logic cfg_per_dev
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [6:0] run;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      run <= 7'h0;
    end else begin
      run <= dq_oe ? run + 7'h1 : 7'h0;
    end
  end
  sequence take_s;
    wr_req && wr_ready;
  endsequence
  sequence resend_s;
    ##[1:40] $rose(wr_cmd);
  endsequence
  ready_drop_a: assert property (take_s |=> !wr_ready)
    else $error("ready held after accept");
  mix_refused_a: assert property (
    take_s ##0 cfg_dm_en && cfg_dbi_en |=> wr_refused)
    else $error("mask with inversion not refused");
  page_refused_a: assert property (
    take_s ##0 cfg_crc_en && (cfg_mpr || cfg_per_dev) |=> wr_refused)
    else $error("page or per-device write not refused");
  alert_resend_a: assert property (wr_rewrite |-> resend_s)
    else $error("no resend after alert");
  done_clean_a: assert property (wr_done |-> alert_n)
    else $error("done while alert low");
  link_half_a: assert property (
    $rose(link_ck) |-> link_ck [*4] ##1 !link_ck)
    else $error("link clock high phase wrong");
  cmd_stand_a: assert property (
    $rose(wr_cmd) |-> (dq_oe && wr_cmd) [*8] ##1 !wr_cmd)
    else $error("command length wrong");
  frame_len_a: assert property (
    $fell(dq_oe) |-> run == (cfg_crc_en ? 7'h50 : 7'h40))
    else $error("frame beat count wrong");
  beat_nine_a: assert property (
    dq_oe && run >= 7'h48 && cfg_crc_en && !cfg_x4
    |-> dq_o == 8'hff && write_byte_mask_n)
    else $error("last beat not ones");
  col_zero_a: assert property (
    wr_cmd && cfg_crc_en |-> col_addr[2:0] == 3'h0)
    else $error("burst column not aligned");
  mask_drive_a: assert property (
    write_byte_mask_oe |-> dq_oe && !cfg_x4)
    else $error("mask pin driven outside frame");
endmodule
bind wcc_host wcc_host_chk i_chk (.*);

// *** verif/wcc_dev_model.sv ***
`timescale 1ns/1ps
// ********
// Device side, one byte lane; a wide part uses two
// ********
module wcc_dev_model (
  input wire logic link_ck,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  input wire logic wr_cmd,
  input wire logic write_byte_mask_n,
  input wire logic cfg_x4,
  input wire logic cfg_crc_en,
  input wire logic cfg_dm_en,
  input wire logic bad,
  output logic alert_n,
  output logic [71:0] word,
  output logic ok
);
  logic [8:0] d [10];
  logic [7:0] rx;
  logic commit;
  int n = -1;
  event frame_ev;
  function automatic logic [7:0] crc8(logic [71:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  initial alert_n = 1'b1;
  always @(posedge link_ck) begin
    if (dq_oe) begin
      n = wr_cmd ? 0 : n + 1;
      d[n] = {write_byte_mask_n, dq_o};
    end else if (n >= 0) begin
      word = '1;
      for (int b = 0; b < 8; b++) begin
        for (int l = 0; l < 9; l++) begin
          if (!cfg_x4 || l < 4) word[l * 8 + b] = d[b][l];
        end
      end
      rx = cfg_x4 ? {d[9][3:0], d[8][3:0]} : d[8][7:0];
      ok = crc8(word) == rx;
      commit = ok || !cfg_dm_en;
      if (cfg_crc_en && (!ok || bad)) begin
        alert_n <= 1'b0;
        alert_n <= #100 1'b1;
      end
      n = -1;
      -> frame_ev;
    end
  end
endmodule

// *** verif/tb_wcc_host.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin \
  n_fail++; $display("FAIL %s exp %h got %h", nm, e, a); end end
// ********
// Bench
// ********
module tb_wcc_host;
  import wcc_pkg::*;
  logic mclk, rst_b, wr_req, wr_ready, wr_refused, wr_done, wr_rewrite;
  logic link_ck, wr_cmd, dq_oe, write_byte_mask_n, write_byte_mask_oe;
  logic cfg_x4, cfg_crc_en, cfg_dm_en, cfg_dbi_en, cfg_pre2, cfg_mpr;
  logic cfg_per_dev, alert_n, ok, bad;
  logic [9:0] wr_col, col_addr;
  logic [63:0] wr_data;
  logic [7:0] wr_byte_mask_n, dq_o;
  wcc_word_t word;
  wcc_word_t exp_w[$];
  logic exp_r[$];
  int n_fail = 0;
  int check_count = 0;
  localparam wcc_word_t CRC0_TAPS = 72'h3d9177298cd0ad51c1;
  logic [8:0] tab [10] = '{9'h080, 9'h190, 9'h0c0, 9'h0a0, 9'h000,
    9'h082, 9'h0c2, 9'h061, 9'h089, 9'h085};
  wcc_host i_wcc_host (.*);
  wcc_dev_model i_wcc_dev_model (.*);
  function automatic wcc_word_t exp_word(logic [8:0] c, logic [63:0] d,
    logic [7:0] m);
    wcc_word_t w;
    int z;
    w = '1;
    for (int b = 0; b < 8; b++) begin
      z = 0;
      for (int l = 0; l < 8; l++) z += !d[l * 8 + b];
      for (int l = 0; l < 8; l++) begin
        if (!c[8] || l < 4) w[l * 8 + b] = d[l * 8 + b] ^ (c[5] && z > 4);
      end
      if (!c[8]) w[64 + b] = c[6] ? m[b] : !(c[5] && z > 4);
    end
    return w;
  endfunction
  task automatic conclude();
    if (exp_w.size() != 0 || exp_r.size() != 0) n_fail++;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic send(input logic [8:0] c);
    logic [63:0] d;
    logic [7:0] m;
    int i;
    d = {$urandom, $urandom};
    m = 8'($urandom);
    exp_r.push_back(c[0]);
    if (!c[0]) repeat (1 + c[1]) exp_w.push_back(exp_word(c, d, m));
    {cfg_x4, cfg_crc_en, cfg_dm_en, cfg_dbi_en} <= c[8:5];
    {cfg_pre2, cfg_mpr, cfg_per_dev, bad} <= c[4:1];
    wr_data <= d;
    wr_byte_mask_n <= m;
    wr_col <= 10'($urandom);
    wr_req <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (wr_ready !== 1'b1 && i < 5000);
    wr_req <= 1'b0;
    do begin
      @(posedge mclk);
      i++;
      if (wr_rewrite === 1'b1) bad <= 1'b0;
    end while (wr_done !== 1'b1 && wr_refused !== 1'b1 && i < 9000);
    repeat (8) @(posedge mclk);
    if (i >= 9000) begin
      n_fail++;
      conclude();
    end
  endtask
  always @(i_wcc_dev_model.frame_ev) begin
    wcc_word_t ew;
    logic p0;
    logic r0;
    ew = exp_w.pop_front();
    #1;
    p0 = ^(word & CRC0_TAPS);
    r0 = i_wcc_dev_model.rx[0];
    `CHK("word", ew, word)
    `CHK("crc", 1'b1, ok | !cfg_crc_en)
    if (cfg_crc_en) `CHK("crc0", p0, r0)
  end
  always @(posedge mclk) begin
    logic er;
    if (wr_done || wr_refused) begin
      er = exp_r.pop_front();
      `CHK("refused", er, wr_refused)
    end
  end
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    {rst_b, wr_req, wr_col, wr_data, wr_byte_mask_n, bad} = '0;
    {cfg_x4, cfg_crc_en, cfg_dm_en, cfg_dbi_en, cfg_pre2} = '0;
    {cfg_mpr, cfg_per_dev} = '0;
    void'($urandom(61769));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int t = 0; t < 10; t++) begin
      repeat (2) send(tab[t]);
      $display("test %0d done", t);
    end
    conclude();
  end
endmodule
